// ===== src/sixteen_bit_async_counter.sv
//----------------------------------------------------------------------
//----------------------------------------------------------------------
//
// Implementation choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "slow_timer_defs.svh"

module sixteen_bit_async_counter
    import slow_timer_pkg::*;
#(
    parameter int COUNT_WIDTH = 16,
    parameter int PRESCALE_WIDTH = 3
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Avalon-MM slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // External counter clock (crystal_in side, sampled by core_clk)
    input wire logic crystal_in,
    input wire logic sleeping,
    // Oscillator control and interrupt
    output logic crystal_osc_enable,
    output logic overflow_irq
);

    //------------------------------------------------------------------
    // Elaboration checks
    //------------------------------------------------------------------
    if (COUNT_WIDTH != 16) begin : g_bad_width
        $error("COUNT_WIDTH must be 16");
    end
    if (PRESCALE_WIDTH != 3) begin : g_bad_pre
        $error("PRESCALE_WIDTH must be 3");
    end

    //------------------------------------------------------------------
    // Helpers
    //------------------------------------------------------------------
    // Tick when the low 'sel' prescale bits have all reached ones
    function automatic logic prescale_done(input logic [2:0] cnt, input logic [1:0] sel);
        logic done;
        done = 1'b0;
        case (sel)
            2'h0: done = 1'b1;
            2'h1: done = cnt[0];
            2'h2: done = &cnt[1:0];
            2'h3: done = &cnt[2:0];
            default: done = 1'b1;
        endcase
        return done;
    endfunction

    function automatic logic [7:0] merge_byte(input logic [7:0] old,
                                              input logic [7:0] wd,
                                              input logic be);
        return be ? wd : old;
    endfunction

    timer_state_s cur;
    timer_state_s next_cur;

    logic [7:0] addrByte;
    logic busWrite;
    logic busRead;
    logic extEdge;
    logic srcExternal;
    logic countEdge;
    logic tick;
    logic wrap;
    logic countWrite;
    logic statusClear;

    assign addrByte = {3'h0, avs_address};
    assign busWrite = avs_write && (cur.busState == BUS_IDLE);
    assign busRead = avs_read && (cur.busState == BUS_IDLE);
    assign srcExternal = cur.control[`CTL_SRC_HI:`CTL_SRC_LO] == 2'h2;
    assign countWrite = busWrite && avs_byteenable[0]
        && (addrByte[4:0] == 5'(`OFS_COUNT_LOW) || addrByte[4:0] == 5'(`OFS_COUNT_HIGH));
    // Software clear of the overflow flag, taken only from an idle bus
    assign statusClear = busWrite && avs_byteenable[0]
        && addrByte[4:0] == 5'(`OFS_IRQ_STATUS) && avs_writedata[0];

    //------------------------------------------------------------------
    // Counter clock selection
    //------------------------------------------------------------------
    // Edge on the synchronised sample in both modes; bypass only removes the
    // sleeping gate, so external edges are still counted while the core
    // sleeps, taken from the same sample with the same latency.
    // bypass ignores sleeping
    assign extEdge = cur.control[`CTL_SYNC_BYPASS] ? (cur.extSync2 & ~cur.extPrev)
                                                   : (cur.extSync2 & ~cur.extPrev & ~sleeping);
    assign countEdge = srcExternal ? extEdge : ~sleeping;
    assign tick = countEdge && prescale_done(cur.prescale,
                    cur.control[`CTL_PRE_HI:`CTL_PRE_LO]);
    assign wrap = tick && cur.control[`CTL_RUN] && (cur.count == 16'hffff);

    //------------------------------------------------------------------
    // Next state
    //------------------------------------------------------------------
    always_comb begin
        next_cur = cur;
        next_cur.extSync1 = crystal_in;
        next_cur.extSync2 = cur.extSync1;
        next_cur.extPrev = cur.extSync2;
        // Prescaler advances on every counter-clock edge while running
        if (countEdge && cur.control[`CTL_RUN]) begin
            next_cur.prescale = tick ? `PRESCALE_RESET : 3'(cur.prescale + 3'h1);
        end
        if (tick && cur.control[`CTL_RUN]) begin
            next_cur.count = 16'(cur.count + 16'h0001);
        end
        // Bus handshake: one wait cycle, then answer
        // The dead cycle after the answer lets a master that still holds
        // its request for one edge go unseen, so a write never lands twice.
        // The price is a minimum spacing of three cycles between requests.
        case (cur.busState)
            BUS_IDLE: begin
                next_cur.waitRequest = 1'b1;
                if (avs_read || avs_write) begin
                    next_cur.busState = BUS_ANSWER;
                    next_cur.waitRequest = 1'b0;
                end
            end
            BUS_ANSWER: begin
                next_cur.busState = BUS_DONE;
                next_cur.waitRequest = 1'b1;
            end
            BUS_DONE: begin
                next_cur.busState = BUS_IDLE;
                next_cur.waitRequest = 1'b1;
            end
            default: begin
                next_cur.busState = BUS_IDLE;
                next_cur.waitRequest = 1'b1;
            end
        endcase
        if (busWrite && avs_byteenable[0]) begin
            case (addrByte[4:0])
                5'(`OFS_COUNT_LOW):
                    next_cur.count[7:0] = avs_writedata[7:0];
                5'(`OFS_COUNT_HIGH):
                    next_cur.count[15:8] = avs_writedata[7:0];
                5'(`OFS_CONTROL):
                    next_cur.control = merge_byte(cur.control, avs_writedata[7:0], 1'b1)
                                       & `CTL_WMASK;
                5'(`OFS_GATE):
                    next_cur.gate = avs_writedata[7:0];
                5'(`OFS_IRQ_MASK):
                    next_cur.overflowMask = avs_writedata[0];
                default: begin
                end
            endcase
        end
        if (countWrite) begin
            next_cur.prescale = `PRESCALE_RESET;
        end
        // Write-one-to-clear; a same-cycle wrap keeps the flag set
        if (busWrite && avs_byteenable[0] && addrByte[4:0] == 5'(`OFS_IRQ_STATUS)
            && avs_writedata[0]) begin
            next_cur.overflowFlag = 1'b0;
        end
        if (wrap) begin
            next_cur.overflowFlag = 1'b1;
        end
        next_cur.irq = next_cur.overflowFlag & next_cur.overflowMask;
        next_cur.oscEnable = next_cur.control[`CTL_OSC_EN];
        // Reads are taken from the registered count, never from the raw pin
        // side, so a byte cannot be caught halfway through a carry.
        // The two bytes are not latched together: a carry between two reads
        // is left for software to spot, as with the original part.
        // coherent read from core copy
        if (busRead) begin
            case (addrByte[4:0])
                5'(`OFS_COUNT_LOW): next_cur.readData = {24'h0, cur.count[7:0]};
                5'(`OFS_COUNT_HIGH): next_cur.readData = {24'h0, cur.count[15:8]};
                5'(`OFS_CONTROL): next_cur.readData = {24'h0, cur.control};
                5'(`OFS_GATE): next_cur.readData = {24'h0, cur.gate};
                5'(`OFS_IRQ_STATUS): next_cur.readData = {31'h0, cur.overflowFlag};
                5'(`OFS_IRQ_MASK): next_cur.readData = {31'h0, cur.overflowMask};
                default: next_cur.readData = 32'h0;
            endcase
        end
    end

    //------------------------------------------------------------------
    // State register
    //------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cur <= '{control: `CONTROL_RESET, gate: `GATE_RESET, count: `COUNT_RESET,
                     prescale: `PRESCALE_RESET, readData: 32'h0, waitRequest: 1'b1,
                     busState: BUS_IDLE, default: 1'b0};
        end else begin
            cur <= next_cur;
        end
    end

    assign avs_readdata = cur.readData;
    assign avs_waitrequest = cur.waitRequest;
    assign crystal_osc_enable = cur.oscEnable;
    assign overflow_irq = cur.irq;

    //------------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    // Prescaler and counting
    // divide by eight
    div_eight_a: assert property (tick && cur.control[`CTL_PRE_HI:`CTL_PRE_LO] == 2'h3
        |-> cur.prescale == 3'h7) else $error("divide by 8 tick early");

    pre_hold_a: assert property (!cur.control[`CTL_RUN] && !countWrite
        |=> $stable(cur.prescale)) else $error("prescaler moved when stopped");

    pre_clear_a: assert property (countWrite |=> cur.prescale == 3'h0)
        else $error("prescaler not cleared");

    count_inc_a: assert property (tick && cur.control[`CTL_RUN] && !countWrite
        |=> cur.count == 16'($past(cur.count) + 16'h0001)) else $error("no increment");

    // wrap sets flag
    // A count write in the wrap cycle wins, so the zero is not expected then
    wrap_flag_a: assert property (wrap && !countWrite
        |=> cur.overflowFlag && cur.count == 16'h0000) else $error("wrap missing flag");

    run_hold_a: assert property (!cur.control[`CTL_RUN] && !busWrite
        |=> $stable(cur.count)) else $error("count moved when stopped");

    // Overflow flag and interrupt
    // clear drops flag
    status_clear_a: assert property (statusClear && !wrap |=> !cur.overflowFlag)
        else $error("overflow flag not cleared");

    flag_sticky_a: assert property (cur.overflowFlag && !statusClear
        |=> cur.overflowFlag) else $error("overflow flag lost");

    set_wins_a: assert property (wrap && statusClear |=> cur.overflowFlag)
        else $error("clear beat a same-cycle wrap");

    irq_level_a: assert property (cur.overflowFlag && cur.overflowMask |-> overflow_irq)
        else $error("irq missing");

    irq_mask_a: assert property (!cur.overflowMask |-> !overflow_irq)
        else $error("irq raised while masked");

    // Clock source and sleep
    // oscillator follows bit
    osc_follow_a: assert property (cur.control[`CTL_OSC_EN] |-> ##[0:1] crystal_osc_enable)
        else $error("oscillator not enabled");

    ext_count_a: assert property (srcExternal && !sleeping && extEdge |-> countEdge)
        else $error("external edge dropped");

    bypass_edge_a: assert property (cur.control[`CTL_SYNC_BYPASS]
        && cur.extSync2 && !cur.extPrev |-> extEdge) else $error("bypass edge dropped");

    // synchronised mode sleeps
    // Without bypass the edge path rides on core phases that stop in sleep
    sync_sleep_a: assert property (sleeping && !cur.control[`CTL_SYNC_BYPASS]
        |-> !extEdge) else $error("synchronised edge seen in sleep");

    sleep_hold_a: assert property (sleeping && !srcExternal && !busWrite
        |=> $stable(cur.count)) else $error("core clock counted in sleep");

    // Register bus
    // read answers within two
    read_ans_a: assert property (busRead |-> ##[1:2] !avs_waitrequest)
        else $error("read not answered");

    answer_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer held too long");

    write_ans_a: assert property (busWrite |=> !avs_waitrequest)
        else $error("write not answered");

    byte_read_a: assert property (busRead |=> avs_readdata[31:8] == 24'h0)
        else $error("read data wider than a byte");

    // Main scenarios that the bench should reach
    wrap_c: cover property (wrap);
    ext_tick_c: cover property (srcExternal && tick);
    clear_race_c: cover property (wrap && busWrite);
    sleep_count_c: cover property (sleeping && tick && cur.control[`CTL_RUN]);
    count_race_c: cover property (countWrite && tick);

endmodule // sixteen_bit_async_counter
`default_nettype wire

// ===== src/slow_timer_defs.svh
`ifndef SLOW_TIMER_DEFS_SVH
`define SLOW_TIMER_DEFS_SVH
// Register word offsets (byte addresses, one aligned word each)
`define OFS_COUNT_LOW 4'h0
`define OFS_COUNT_HIGH 4'h4
`define OFS_CONTROL 4'h8
`define OFS_GATE 4'hc
`define OFS_IRQ_STATUS 5'h10
`define OFS_IRQ_MASK 5'h14
// Control register fields
`define CTL_SRC_HI 7
`define CTL_SRC_LO 6
`define CTL_PRE_HI 5
`define CTL_PRE_LO 4
`define CTL_OSC_EN 3
`define CTL_SYNC_BYPASS 2
`define CTL_RUN 0
`define CTL_WMASK 8'hfd
`define CONTROL_RESET 8'h00
`define GATE_RESET 8'h00
`define COUNT_RESET 16'h0000
`define PRESCALE_RESET 3'h0
`endif

// ===== src/slow_timer_pkg.sv
package slow_timer_pkg;
    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_ANSWER = 3'b010,
        BUS_DONE = 3'b100
    } bus_state_e;

    typedef struct packed {
        logic [7:0] control;
        logic [7:0] gate;
        logic [15:0] count;
        logic [2:0] prescale;
        logic extPrev;
        logic extSync1;
        logic extSync2;
        logic overflowFlag;
        logic overflowMask;
        logic irq;
        logic oscEnable;
        logic [31:0] readData;
        logic waitRequest;
        bus_state_e busState;
    } timer_state_s;
endpackage

// ===== tb/crystal_model.sv
`timescale 1ns/10ps
`default_nettype none

module crystal_model #(
    parameter int HALF_NS = 61
) (
    // Oscillator control
    input wire logic oscEnable,
    // Counter clock
    output logic crystalIn
);
    // runs only while enabled
    // Parks low when stopped, so no stray edge is counted
    initial crystalIn = 1'b0;
    always begin
        #(HALF_NS);
        crystalIn = oscEnable ? ~crystalIn : 1'b0;
    end
endmodule // crystal_model

`default_nettype wire

// ===== tb/test_sixteen_bit_async_counter.sv
`timescale 1ns/10ps
`default_nettype none

module test_sixteen_bit_async_counter;
    logic coreClk = 1'b0;
    logic resetN = 1'b0;
    logic [4:0] avsAddress = 5'h00;
    logic avsRead = 1'b0;
    logic avsWrite = 1'b0;
    logic [31:0] avsWritedata = 32'h0;
    logic [31:0] avsReaddata;
    logic avsWaitrequest;
    logic crystalIn;
    logic sleeping = 1'b0;
    logic oscEnable;
    logic overflowIrq;
    logic [31:0] rd;
    logic [31:0] a;
    int miscompares = 0;
    int checkCount = 0;

    // Clock, 4 ns period
    always #2 coreClk = ~coreClk;

    sixteen_bit_async_counter dut (
        .core_clk(coreClk), .reset_n(resetN), .avs_address(avsAddress),
        .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWritedata),
        .avs_byteenable(4'h1), .avs_readdata(avsReaddata),
        .avs_waitrequest(avsWaitrequest), .crystal_in(crystalIn), .sleeping(sleeping),
        .crystal_osc_enable(oscEnable), .overflow_irq(overflowIrq)
    );

    crystal_model xtal (.oscEnable(oscEnable), .crystalIn(crystalIn));

    // ----
    // Bus and compare helpers
    // ----
    // Request held until waitrequest is seen low; bounded wait
    task automatic bus(input logic wr, input logic [4:0] ad, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge coreClk);
        avsAddress <= ad;
        avsWrite <= wr;
        avsRead <= ~wr;
        avsWritedata <= wd;
        do begin
            @(posedge coreClk);
            n++;
        end while (avsWaitrequest !== 1'b0 && n < 20);
        rd = avsReaddata;
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
        if (n >= 20) miscompares++;
    endtask

    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        checkCount++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL %0t exp %h got %h", $time, exp, got);
        end
    endtask

    // ----
    // Scenarios
    // ----
    task automatic t_regs();
        bus(0, 5'h08, 0);
        chk(0, rd);
        bus(0, 5'h18, 0);
        chk(0, rd);
        bus(1, 5'h08, 32'h3e);
        bus(0, 5'h08, 0);
        chk(32'h3c, rd);
        chk(1, oscEnable);
        bus(1, 5'h08, 0);
        bus(0, 5'h00, 0);
        chk(0, oscEnable);
        $display("done regs");
    endtask

    // Count over w idle cycles; count write clears the prescaler first
    task automatic measure(input logic [1:0] ps, input int w);
        bus(1, 5'h00, 0);
        bus(1, 5'h04, 0);
        bus(1, 5'h08, {26'h0, ps, 4'h1});
        repeat (w) @(posedge coreClk);
        bus(1, 5'h08, 0);
        bus(0, 5'h00, 0);
    endtask

    // Difference of two runs 64 cycles apart is exact per divide
    task automatic t_prescale();
        for (int p = 0; p < 4; p++) begin
            measure(p[1:0], 8);
            a = rd;
            measure(p[1:0], 72);
            chk(32'd64 >> p, rd - a);
        end
        $display("done prescale");
    endtask

    task automatic t_overflow();
        bus(1, 5'h00, 32'hfe);
        bus(1, 5'h04, 32'hff);
        bus(1, 5'h14, 1);
        bus(1, 5'h08, 1);
        repeat (4) @(posedge coreClk);
        bus(1, 5'h08, 0);
        chk(1, overflowIrq);
        bus(0, 5'h10, 0);
        chk(1, rd);
        bus(0, 5'h04, 0);
        // High byte read after the carry: software must expect the wrap
        chk(0, rd);
        bus(1, 5'h14, 0);
        bus(0, 5'h10, 0);
        chk(0, overflowIrq);
        bus(1, 5'h10, 1);
        bus(0, 5'h10, 0);
        chk(0, rd);
        $display("done overflow");
    endtask

    // External crystal while asleep, with and without sync bypass
    task automatic t_external();
        sleeping <= 1'b1;
        for (int s = 0; s < 2; s++) begin
            bus(1, 5'h08, 32'h88);
            repeat (50) @(posedge coreClk);
            bus(1, 5'h00, 0);
            bus(1, 5'h08, 32'h89 | (s << 2));
            repeat (400) @(posedge coreClk);
            bus(1, 5'h08, 0);
            bus(0, 5'h00, 0);
            // Synchronised mode stops with the core; bypass keeps counting
            if (s == 0) begin
                chk(0, rd);
            end else begin
                chk(1, rd >= 11 && rd <= 15);
            end
        end
        sleeping <= 1'b0;
        $display("done external");
    endtask

    // ----
    // Sequence and verdict
    // ----
    task automatic wrapUp();
        $display("checks %0d mismatches %0d", checkCount, miscompares);
        if (miscompares == 0 && checkCount > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge coreClk);
        resetN <= 1'b1;
        t_regs();
        t_prescale();
        t_overflow();
        t_external();
        wrapUp();
    end

    // Watchdog, well past the fewer than 1500 cycles the tests take
    initial begin
        #40000;
        miscompares++;
        wrapUp();
    end
endmodule // test_sixteen_bit_async_counter

`default_nettype wire
